// file: design/sct_timer.sv
// sixteen bit capture timer: apb register slave, prescaled count clock,
// counter with three running modes, two compare/capture registers,
// sticky status with mask and one level interrupt.
// assumes an apb master on ref_clk and asynchronous capture pins.
//
// Summary of operation
// - first match may lag one count clock
// - capture during read happens; read value undefined
// - capture during read still raises its interrupt
// - compare registers not guaranteed after stop
// - overflow on wrap or match-clear from FFFFH
// - overflow clear ignored until count reaches 0001H
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module sct_timer
  import sct_pkg::*;
#(
  parameter int PRESC_W = 3 // width of the free prescaler
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_input_a,
  input wire logic capture_input_b,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [9:0] ctrl; // timer_mode_control plus prescaler_mode_reg fields
  logic [15:0] timer_count_value; // the counter
  logic [15:0] compare_capture_a;
  logic [15:0] compare_capture_b;
  logic [2:0] status; // sticky events
  logic [2:0] mask; // interrupt enables
  logic ovf_hold; // overflow seen, count not yet 0001H
  logic [PRESC_W-1:0] presc; // free-running prescaler
  logic [9:0] next_ctrl;
  logic [15:0] next_count;
  logic [15:0] next_cca;
  logic [15:0] next_ccb;
  logic [2:0] next_status;
  logic [2:0] next_mask;
  logic next_ovf_hold;
  logic [PRESC_W-1:0] next_presc;
  logic [31:0] next_prdata;
  // decoded controls and events
  sct_mode_t mode;
  logic running;
  logic tick; // count clock pulse
  logic match_a;
  logic match_b;
  logic ovf_ev;
  logic cap_a; // capture into compare_capture_a
  logic cap_b; // capture into compare_capture_b
  logic wr; // apb write access
  logic rd_setup; // apb read setup cycle
  logic [2:0] w1c; // status bits cleared by software
  sct_edge_if eif_a ();
  sct_edge_if eif_b ();

  ////////////////////////////////////////////////////////////////////////////
  // capture pin detectors
  sct_edge_det u_edge_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(capture_input_a),
    .eif(eif_a.det)
  );
  sct_edge_det u_edge_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(capture_input_b),
    .eif(eif_b.det)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode and events
  always_comb
  begin
    mode = sct_mode_t'(ctrl[SCT_CTRL_MODE_LSB +: 2]);
    running = (mode != SCT_MODE_STOP);
    eif_a.edge_sel = sct_edge_t'(ctrl[SCT_CTRL_EDGE_A_LSB +: 2]);
    eif_b.edge_sel = sct_edge_t'(ctrl[SCT_CTRL_EDGE_B_LSB +: 2]);
    // prescaler runs free, so start is not aligned to a tick
    case (ctrl[SCT_CTRL_PRESC_LSB +: 2])
      2'h0: tick = 1'b1;
      2'h1: tick = (presc[0] == 1'b1);
      2'h2: tick = (presc[1:0] == 2'h3);
      default: tick = (presc[2:0] == 3'h7);
    endcase
    match_a = running && tick && !ctrl[SCT_CTRL_CAP_A_BIT]
      && (timer_count_value == compare_capture_a);
    match_b = running && tick && !ctrl[SCT_CTRL_CAP_B_BIT]
      && (timer_count_value == compare_capture_b);
    // captures ignore any read in flight
    cap_a = running && ctrl[SCT_CTRL_CAP_A_BIT] && eif_b.edge_seen;
    cap_b = running && ctrl[SCT_CTRL_CAP_B_BIT] && eif_a.edge_seen;
    // wrap, or match-clear from the top value
    ovf_ev = running && tick && (timer_count_value == SCT_COUNT_MAX)
      && !(mode == SCT_MODE_CLR_EDGE && eif_a.edge_seen);
    wr = psel && penable && pwrite;
    rd_setup = psel && !penable && !pwrite;
    w1c = (wr && paddr == SCT_OFF_STATUS) ? pwdata[2:0] : 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter and prescaler next values
  always_comb
  begin
    next_presc = presc + PRESC_W'(1);
    next_count = timer_count_value;
    if (!running)
      next_count = 16'h0000; // stopped: counter held at zero
    else if (mode == SCT_MODE_CLR_EDGE && eif_a.edge_seen)
      next_count = 16'h0000; // clear and restart on the trigger edge; the counter already runs before it
    else if (tick && mode == SCT_MODE_CLR_MATCH && timer_count_value == compare_capture_a)
      next_count = 16'h0000; // clear on match with compare_capture_a
    else if (tick)
      next_count = timer_count_value + SCT_COUNT_ONE; // wraps at top
    // overflow window lasts until the counter leaves zero
    if (ovf_ev)
      next_ovf_hold = 1'b1;
    else if (!running || timer_count_value != 16'h0000)
      next_ovf_hold = 1'b0;
    else
      next_ovf_hold = ovf_hold;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file next values
  always_comb
  begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_cca = compare_capture_a;
    next_ccb = compare_capture_b;
    if (wr && paddr == SCT_OFF_CTRL)
      next_ctrl = pwdata[SCT_CTRL_WIDTH-1:0];
    else if (wr && paddr == SCT_OFF_MASK)
      next_mask = pwdata[2:0];
    else if (wr && paddr == SCT_OFF_CCA)
      next_cca = pwdata[15:0];
    else if (wr && paddr == SCT_OFF_CCB)
      next_ccb = pwdata[15:0];
    // capture wins over a write; contents simply kept when stopped
    if (cap_a)
      next_cca = timer_count_value;
    if (cap_b)
      next_ccb = timer_count_value;
    // sticky status: set beats clear; a capture edge sets its flag whenever the counter runs, irq only where mask enables it
    // the overflow window re-sets the flag only while the count still reads zero
    next_status[SCT_ST_OVF] = ovf_ev || (ovf_hold && timer_count_value == 16'h0000)
      || (status[SCT_ST_OVF] && !w1c[SCT_ST_OVF]);
    next_status[SCT_ST_IRQ_A] = match_a || cap_a
      || (status[SCT_ST_IRQ_A] && !w1c[SCT_ST_IRQ_A]);
    next_status[SCT_ST_IRQ_B] = match_b || cap_b
      || (status[SCT_ST_IRQ_B] && !w1c[SCT_ST_IRQ_B]);
    // read data loaded in the setup cycle and held until the next read
    next_prdata = prdata;
    if (rd_setup)
    begin
      next_prdata = 32'h0000_0000; // unmapped offsets read zero
      if (paddr == SCT_OFF_CTRL)
        next_prdata = {22'h00_0000, ctrl};
      else if (paddr == SCT_OFF_COUNT)
        next_prdata = {16'h0000, timer_count_value};
      else if (paddr == SCT_OFF_CCA)
        next_prdata = {16'h0000, compare_capture_a}; // may race a capture
      else if (paddr == SCT_OFF_CCB)
        next_prdata = {16'h0000, compare_capture_b}; // may race a capture
      else if (paddr == SCT_OFF_STATUS)
        next_prdata = {29'h0000_0000, status};
      else if (paddr == SCT_OFF_MASK)
        next_prdata = {29'h0000_0000, mask};
    end
  end

  // apb answer: zero wait states, error on unmapped offsets
  always_comb
  begin
    pready = 1'b1;
    pslverr = psel && penable && !(paddr == SCT_OFF_CTRL || paddr == SCT_OFF_COUNT
      || paddr == SCT_OFF_CCA || paddr == SCT_OFF_CCB
      || paddr == SCT_OFF_STATUS || paddr == SCT_OFF_MASK);
  end

  ////////////////////////////////////////////////////////////////////////////
  // all registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl <= SCT_CTRL_RST;
      timer_count_value <= 16'h0000;
      compare_capture_a <= SCT_CC_RST;
      compare_capture_b <= SCT_CC_RST;
      status <= 3'h0;
      mask <= SCT_MASK_RST;
      ovf_hold <= 1'b0;
      presc <= '0;
      prdata <= 32'h0000_0000;
      irq <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      timer_count_value <= next_count;
      compare_capture_a <= next_cca;
      compare_capture_b <= next_ccb;
      status <= next_status;
      mask <= next_mask;
      ovf_hold <= next_ovf_hold;
      presc <= next_presc;
      prdata <= next_prdata;
      irq <= |(next_status & next_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_top_tick;
    running && tick && timer_count_value == SCT_COUNT_MAX
      && !(mode == SCT_MODE_CLR_EDGE && eif_a.edge_seen);
  endsequence
  property p_wrap;
    @(posedge ref_clk) disable iff (rst)
    s_top_tick |=> timer_count_value == 16'h0000 && status[SCT_ST_OVF];
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to zero with overflow");
  property p_incr;
    @(posedge ref_clk) disable iff (rst)
    (running && tick && mode == SCT_MODE_FREE && !$changed(ctrl))
      |=> timer_count_value == $past(timer_count_value) + SCT_COUNT_ONE;
  endproperty
  a_incr: assert property (p_incr) else $error("counter did not step");
  property p_match_clr_ovf;
    @(posedge ref_clk) disable iff (rst)
    (mode == SCT_MODE_CLR_MATCH && tick && compare_capture_a == SCT_COUNT_MAX
      && timer_count_value == SCT_COUNT_MAX) |=> status[SCT_ST_OVF];
  endproperty
  a_match_clr_ovf: assert property (p_match_clr_ovf) else $error("match clear lost ovf");
  property p_ovf_sticky_window;
    @(posedge ref_clk) disable iff (rst)
    (ovf_hold && timer_count_value == 16'h0000 && w1c[SCT_ST_OVF]) |=> status[SCT_ST_OVF];
  endproperty
  a_ovf_sticky_window: assert property (p_ovf_sticky_window) else $error("ovf cleared early");
  property p_cap_irq;
    @(posedge ref_clk) disable iff (rst)
    (cap_a && psel && !pwrite)
      |=> status[SCT_ST_IRQ_A] ##0 compare_capture_a == $past(timer_count_value);
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture during read lost");
  property p_cap_b;
    @(posedge ref_clk) disable iff (rst)
    cap_b |=> compare_capture_b == $past(timer_count_value) && status[SCT_ST_IRQ_B];
  endproperty
  a_cap_b: assert property (p_cap_b) else $error("capture b failed");
  property p_start_lag;
    @(posedge ref_clk) disable iff (rst)
    ($rose(running) && ctrl[SCT_CTRL_PRESC_LSB +: 2] == 2'h1)
      |-> ##[1:2] timer_count_value != 16'h0000 || !running;
  endproperty
  a_start_lag: assert property (p_start_lag) else $error("start lag over one tick");
  property p_stop_hold;
    @(posedge ref_clk) disable iff (rst)
    (!running && !wr && !$past(running)) |=> $stable(compare_capture_a);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped cca moved");
  property p_irq_level;
    @(posedge ref_clk) disable iff (rst)
    ##1 irq == |(status & mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not status and mask");
endmodule

// file: design/sct_pkg.sv
// package for the sixteen bit capture timer: register map, field positions,
// reset values and the mode and edge encodings shared by the design files.
// assumes a 32-bit apb register bus and a single 50 MHz clock.
package sct_pkg;
  // register byte offsets
  localparam logic [7:0] SCT_OFF_CTRL = 8'h00;
  localparam logic [7:0] SCT_OFF_COUNT = 8'h04;
  localparam logic [7:0] SCT_OFF_CCA = 8'h08;
  localparam logic [7:0] SCT_OFF_CCB = 8'h0C;
  localparam logic [7:0] SCT_OFF_STATUS = 8'h10;
  localparam logic [7:0] SCT_OFF_MASK = 8'h14;
  // control field positions
  localparam int SCT_CTRL_MODE_LSB = 0;
  localparam int SCT_CTRL_PRESC_LSB = 2;
  localparam int SCT_CTRL_EDGE_A_LSB = 4;
  localparam int SCT_CTRL_EDGE_B_LSB = 6;
  localparam int SCT_CTRL_CAP_A_BIT = 8;
  localparam int SCT_CTRL_CAP_B_BIT = 9;
  localparam int SCT_CTRL_WIDTH = 10;
  // status and mask bit positions
  localparam int SCT_ST_OVF = 0;
  localparam int SCT_ST_IRQ_A = 1;
  localparam int SCT_ST_IRQ_B = 2;
  // values after reset
  localparam logic [9:0] SCT_CTRL_RST = 10'h000;
  localparam logic [15:0] SCT_CC_RST = 16'h0000;
  localparam logic [2:0] SCT_MASK_RST = 3'h0;
  // counter limits
  localparam logic [15:0] SCT_COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] SCT_COUNT_ONE = 16'h0001;
  // operating modes (operating_mode_bits)
  typedef enum logic [1:0] {
    SCT_MODE_STOP,
    SCT_MODE_FREE,
    SCT_MODE_CLR_EDGE,
    SCT_MODE_CLR_MATCH
  } sct_mode_t;
  // active edge selection (edge_select_bits)
  typedef enum logic [1:0] {
    SCT_EDGE_FALL,
    SCT_EDGE_RISE,
    SCT_EDGE_NONE,
    SCT_EDGE_BOTH
  } sct_edge_t;
endpackage

// file: design/sct_edge_if.sv
// interface between the timer core and one capture pin edge detector.
// assumes both ends run on ref_clk.
`timescale 1ns/1ps
interface sct_edge_if;
  import sct_pkg::*;
  sct_edge_t edge_sel; // which edge counts as valid
  logic edge_seen; // one-cycle pulse on a valid edge
  modport det (input edge_sel, output edge_seen);
  modport user (output edge_sel, input edge_seen);
endinterface

// file: design/sct_edge_det.sv
// edge detector for one external capture pin: two-flop synchroniser, then
// selectable edge detection. assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ps
module sct_edge_det
  import sct_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin,
  sct_edge_if.det eif
);
  logic sync_1; // first synchroniser stage, read only by sync_2
  logic sync_2; // second synchroniser stage
  logic last; // previous synchronised level
  logic next_seen;

  ////////////////////////////////////////////////////////////////////////////
  // edge decode on the synchronised level
  always_comb
  begin
    case (eif.edge_sel)
      SCT_EDGE_FALL: next_seen = last & ~sync_2;
      SCT_EDGE_RISE: next_seen = ~last & sync_2;
      SCT_EDGE_BOTH: next_seen = last ^ sync_2;
      default: next_seen = 1'b0;
    endcase
  end

  // synchroniser and edge pulse register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync_1 <= 1'b0;
      sync_2 <= 1'b0;
      last <= 1'b0;
      eif.edge_seen <= 1'b0;
    end
    else
    begin
      sync_1 <= pin;
      sync_2 <= sync_1;
      last <= sync_2;
      eif.edge_seen <= next_seen;
    end
  end
endmodule

// file: verif/sct_pin_src.sv
// partner model: drives the two capture pins of the timer.
// assumes it shares ref_clk with the timer; pins idle low between pulses.
`timescale 1ns/1ps
module sct_pin_src
(
  input wire logic ref_clk,
  output logic pin_a,
  output logic pin_b
);
  // pins start low
  initial
  begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // one pulse of width clocks, wide enough for the two-flop synchroniser
  task automatic pulse(input logic sel_b, input int width);
    begin
      @(posedge ref_clk);
      if (sel_b)
        pin_b <= 1'b1;
      else
        pin_a <= 1'b1;
      repeat (width) @(posedge ref_clk);
      if (sel_b)
        pin_b <= 1'b0;
      else
        pin_a <= 1'b0;
      // rest before any further trigger may follow
      repeat (width) @(posedge ref_clk);
    end
  endtask
endmodule

// file: verif/sct_timer_bench.sv
// self-checking bench for the capture timer: apb master tasks and scenarios.
// assumes the timer and the pin source model share one 50 MHz clock.
`timescale 1ns/1ps
module sct_timer_bench;
  import sct_pkg::*;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, irq, cap_a, cap_b;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int miscompares = 0;
  int tests_run = 0;
  sct_timer sct_timer_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_input_a(cap_a), .capture_input_b(cap_b), .irq(irq));
  sct_pin_src sct_pin_src_inst (.ref_clk(ref_clk), .pin_a(cap_a), .pin_b(cap_b));
  ////////////////////////////////////////////////////////////////////////////
  // 20 ns clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    begin
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // compare one value against its expectation
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    begin
      tests_run++;
      if (seen !== exp)
      begin
        miscompares++;
        $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // one apb transfer: setup, access held until pready, then one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge ref_clk);
        n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
        miscompares++;
        print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    xfer(1'b0, a, 32'h0000_0000, d, e);
  endtask
  // bounded wait for the interrupt line
  task automatic wait_irq(input int lim);
    int n;
    begin
      n = 0;
      while (irq !== 1'b1 && n < lim)
      begin
        @(posedge ref_clk);
        n++;
      end
      if (irq !== 1'b1)
      begin
        miscompares++;
        print_verdict();
      end
    end
  endtask
  // control word from its fields
  function automatic logic [31:0] ctl(input logic [1:0] m, p, ea, eb, input logic ca, cb);
    ctl = 32'h0000_0000;
    ctl[SCT_CTRL_MODE_LSB +: 2] = m;
    ctl[SCT_CTRL_PRESC_LSB +: 2] = p;
    ctl[SCT_CTRL_EDGE_A_LSB +: 2] = ea;
    ctl[SCT_CTRL_EDGE_B_LSB +: 2] = eb;
    ctl[SCT_CTRL_CAP_A_BIT] = ca;
    ctl[SCT_CTRL_CAP_B_BIT] = cb;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // reset values, unmapped access, irq and pready after reset
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    begin
      for (int i = 0; i < 6; i++)
      begin
        reg_rd(8'(4 * i), r);
        chk("reset value", r, 32'h0000_0000);
      end
      xfer(1'b1, 8'h18, 32'h0000_0007, r, e);
      chk("unmapped write error", e, 1'b1);
      xfer(1'b0, 8'h18, 32'h0000_0000, r, e);
      chk("unmapped read error", e, 1'b1);
      chk("unmapped read data", r, 32'h0000_0000);
      chk("irq after reset", irq, 1'b0);
      chk("pready idle", pready, 1'b1);
      $display("test reset done");
    end
  endtask
  // count rate for every prescaler code, stopped counter holds zero
  task automatic t_count();
    logic [31:0] c0, c1;
    begin
      for (int p = 0; p < 4; p++)
      begin
        reg_wr(SCT_OFF_CTRL, ctl(SCT_MODE_FREE, 2'(p), SCT_EDGE_NONE, SCT_EDGE_NONE, 1'b0, 1'b0));
        reg_rd(SCT_OFF_COUNT, c0);
        repeat (21) @(posedge ref_clk);
        reg_rd(SCT_OFF_COUNT, c1);
        chk("count step", c1 - c0, 32'(24 >> p));
      end
      // a start from stop lags the first tick by at most one count clock
      reg_wr(SCT_OFF_CTRL, ctl(SCT_MODE_STOP, 2'h0, SCT_EDGE_NONE, SCT_EDGE_NONE, 1'b0, 1'b0));
      reg_wr(SCT_OFF_CTRL, ctl(SCT_MODE_FREE, 2'h1, SCT_EDGE_NONE, SCT_EDGE_NONE, 1'b0, 1'b0));
      reg_rd(SCT_OFF_COUNT, c0);
      chk("start lag", c0 <= 1, 1'b1);
      reg_wr(SCT_OFF_CTRL, ctl(SCT_MODE_STOP, 2'h0, SCT_EDGE_NONE, SCT_EDGE_NONE, 1'b0, 1'b0));
      reg_rd(SCT_OFF_COUNT, c0);
      chk("stopped count", c0, 32'h0000_0000);
      $display("test count done");
    end
  endtask
  // clear on match at FFFFH sets the overflow flag; early clear ignored, later one works
  task automatic t_ovf();
    logic [31:0] s, c;
    begin
      reg_wr(SCT_OFF_CCA, 32'h0000_FFFF);
      reg_wr(SCT_OFF_CCB, 32'h0000_0001);
      reg_wr(SCT_OFF_MASK, 32'h0000_0001);
      reg_wr(SCT_OFF_CTRL, ctl(SCT_MODE_CLR_MATCH, 2'h0, SCT_EDGE_NONE, SCT_EDGE_NONE,
        1'b0, 1'b0));
      // the clear access lands in the cycle in which the count first reads zero again
      repeat (65534) @(posedge ref_clk);
      reg_wr(SCT_OFF_STATUS, 32'h0000_0001);
      chk("early clear ignored", irq, 1'b1);
      reg_rd(SCT_OFF_STATUS, s);
      chk("overflow flag", s[SCT_ST_OVF], 1'b1);
      chk("match a flag", s[SCT_ST_IRQ_A], 1'b1);
      reg_rd(SCT_OFF_COUNT, c);
      chk("cleared count small", c < 16, 1'b1);
      reg_wr(SCT_OFF_STATUS, 32'h0000_0001);
      reg_rd(SCT_OFF_STATUS, s);
      chk("overflow cleared", s[SCT_ST_OVF], 1'b0);
      chk("irq after clear", irq, 1'b0);
      reg_wr(SCT_OFF_CTRL, ctl(SCT_MODE_STOP, 2'h0, SCT_EDGE_NONE, SCT_EDGE_NONE, 1'b0, 1'b0));
      reg_wr(SCT_OFF_STATUS, 32'h0000_0007);
      $display("test overflow done");
    end
  endtask
  // capture edge arriving while the capture register is being read
  task automatic t_capture();
    logic [31:0] v, c, s;
    begin
      reg_wr(SCT_OFF_CTRL, ctl(SCT_MODE_STOP, 2'h0, SCT_EDGE_NONE, SCT_EDGE_RISE,
        1'b1, 1'b0));
      reg_wr(SCT_OFF_MASK, 32'h0000_0002);
      reg_wr(SCT_OFF_CTRL, ctl(SCT_MODE_FREE, 2'h0, SCT_EDGE_NONE, SCT_EDGE_RISE, 1'b1, 1'b0));
      repeat (50) @(posedge ref_clk);
      fork
        sct_pin_src_inst.pulse(1'b1, 6);
        for (int i = 0; i < 6; i++)
          reg_rd(SCT_OFF_CCA, v);
      join
      wait_irq(20);
      chk("capture irq", irq, 1'b1);
      reg_rd(SCT_OFF_STATUS, s);
      chk("capture flag", s[SCT_ST_IRQ_A], 1'b1);
      reg_rd(SCT_OFF_CCA, v);
      reg_rd(SCT_OFF_COUNT, c);
      chk("captured value", v != 0 && v < c, 1'b1);
      reg_wr(SCT_OFF_STATUS, 32'h0000_0007);
      $display("test capture done");
    end
  endtask
  // every edge selection of pin a capturing into b, mask gating the irq
  task automatic t_edges();
    logic [31:0] s, r;
    begin
      reg_wr(SCT_OFF_MASK, 32'h0000_0000);
      for (int e = 0; e < 4; e++)
      begin
        reg_wr(SCT_OFF_CTRL, ctl(SCT_MODE_STOP, 2'h0, 2'(e), SCT_EDGE_NONE, 1'b0, 1'b1));
        reg_wr(SCT_OFF_STATUS, 32'h0000_0007);
        reg_wr(SCT_OFF_CTRL, ctl(SCT_MODE_FREE, 2'h0, 2'(e), SCT_EDGE_NONE, 1'b0, 1'b1));
        reg_rd(SCT_OFF_CTRL, r);
        chk("control readback", r, ctl(SCT_MODE_FREE, 2'h0, 2'(e), SCT_EDGE_NONE, 1'b0, 1'b1));
        sct_pin_src_inst.pulse(1'b0, 6);
        repeat (8) @(posedge ref_clk);
        reg_rd(SCT_OFF_STATUS, s);
        chk("edge capture flag", s[SCT_ST_IRQ_B], e != SCT_EDGE_NONE);
        chk("masked irq", irq, 1'b0);
      end
      reg_wr(SCT_OFF_MASK, 32'h0000_0004);
      chk("unmasked irq", irq, 1'b1);
      reg_wr(SCT_OFF_STATUS, 32'h0000_0004);
      chk("irq after clear", irq, 1'b0);
      $display("test edges done");
    end
  endtask
  // clear and restart on a pin a edge
  task automatic t_mode2();
    logic [31:0] c;
    begin
      reg_wr(SCT_OFF_CTRL, ctl(SCT_MODE_STOP, 2'h0, SCT_EDGE_RISE, SCT_EDGE_NONE,
        1'b0, 1'b0));
      reg_wr(SCT_OFF_CTRL, ctl(SCT_MODE_CLR_EDGE, 2'h0, SCT_EDGE_RISE, SCT_EDGE_NONE,
        1'b0, 1'b0));
      repeat (100) @(posedge ref_clk);
      sct_pin_src_inst.pulse(1'b0, 6);
      reg_rd(SCT_OFF_COUNT, c);
      chk("count after edge clear", c < 40, 1'b1);
      $display("test edge clear done");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_count();
    t_ovf();
    t_capture();
    t_edges();
    t_mode2();
    print_verdict();
  end
endmodule
